// ### include/ext_irq_pkg.sv
// Package with register map, field layout and sense encodings of the external interrupt unit
package ext_irq_pkg;

  localparam int ADDR_W  = 10;
  localparam int DATA_W  = 32;
  localparam int REG_W   = 8;
  localparam int N_EXT   = 3;
  localparam int N_GRP   = 4;
  localparam int GRP_W   = 8;
  localparam int N_PCI   = N_GRP * GRP_W;
  localparam int SENSE_W = 2 * N_EXT;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_SENSE_CONTROL = 8'h69;
  localparam logic [7:0] IDX_MASK3         = 8'h73;
  localparam logic [7:0] IDX_MASK2         = 8'h6d;
  localparam logic [7:0] IDX_MASK1         = 8'h74;
  localparam logic [7:0] IDX_MASK0         = 8'h75;
  localparam logic [7:0] IDX_EXT_ENABLE    = 8'h40;
  localparam logic [7:0] IDX_EXT_FLAGS     = 8'h41;
  localparam logic [7:0] IDX_GRP_ENABLE    = 8'h42;
  localparam logic [7:0] IDX_GRP_FLAGS     = 8'h43;

  localparam logic [REG_W-1:0] RESET_VAL  = 8'h00;
  localparam logic [1:0]       BYTE_SHIFT = 2'h0;

  // Narrowest pin pulse that is always caught, one clock period at 40 MHz
  localparam int CLK_PERIOD_NS     = 25;
  localparam int MIN_PULSE_NS      = 25;
  localparam int MIN_PULSE_CYCLES  = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SENSE_LOW  = 2'b00,
    SENSE_ANY  = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } sense_t;

endpackage

// ### verilog/pin_sync.sv
// Module with a two flip-flop synchroniser for a bus of independent levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1_reg;

  // The first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule

// ### verilog/sense_detect.sv
// Module that decodes the sense selector of each external request pin
`timescale 1ns/1ps
module sense_detect #(
  parameter int N = 3
) (
  input  wire logic [2*N-1:0] sense_select,
  input  wire logic [N-1:0]   cur,
  input  wire logic [N-1:0]   prev,
  output logic      [N-1:0]   edge_fire,
  output logic      [N-1:0]   level_mode,
  output logic      [N-1:0]   level_low
);

  always_comb begin
    edge_fire  = '0;
    level_mode = '0;
    level_low  = '0;
    for (int i = 0; i < N; i++) begin
      unique case (ext_irq_pkg::sense_t'(sense_select[2*i +: 2]))
        ext_irq_pkg::SENSE_LOW: begin
          level_mode[i] = 1'b1;
          level_low[i]  = ~cur[i];
        end
        ext_irq_pkg::SENSE_ANY:  edge_fire[i] = cur[i] ^ prev[i];
        ext_irq_pkg::SENSE_FALL: edge_fire[i] = prev[i] & ~cur[i];
        ext_irq_pkg::SENSE_RISE: edge_fire[i] = cur[i] & ~prev[i];
      endcase
    end
  end

endmodule

// ### verilog/external_pin_interrupt_unit.sv
// External pin and pin-change interrupt unit with an APB register slave
`timescale 1ns/1ps
// Notes on behaviour
// - Requests fire regardless of pin direction; software may drive its own pin.
// - Group 3 covers inputs 31:24, 2 covers 23:16, 1 15:8, 0 7:0.
// - Pin changes reach the wake output without needing the clock.
// - Sense select 00 low level, 01 any edge, 10 falling, 11 rising.
// - Enabled low-level sensing requests for as long as the pin stays low.
// - Low levels and edges on request pins wake without the clock.
// - Level gone before start-up ends gives a wake-up but no interrupt.
// - Top two bits of sense control read zero.
// - Request pin interrupts need both global flag and its enable bit.
// - Selected edge sets the pin flag; vector taken with global flag and enable.
// - Flags clear on vector entry and on writing one.
// - In level mode the pin flag is held cleared.
// - Sleep with request disabled cuts the input buffer; may set the flag.
// - Group requests need group enable and global flag; own vector each.
// - Only inputs whose mask bit is set feed the group request.
// - A masked change sets the group flag; vector when enabled globally.
// - Pulses wider than the minimum width always produce an interrupt.
// - Mask bit alone enables detection into the group flag; group enable gates request and wake; cleared mask disables it.
module external_pin_interrupt_unit #(
  parameter int N_EXT = ext_irq_pkg::N_EXT,
  parameter int N_GRP = ext_irq_pkg::N_GRP,
  parameter int GRP_W = ext_irq_pkg::GRP_W
) (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [ext_irq_pkg::ADDR_W-1:0] paddr,
  input  wire logic [ext_irq_pkg::DATA_W-1:0] pwdata,
  output logic      [ext_irq_pkg::DATA_W-1:0] prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic [N_EXT-1:0]               external_request_pins,
  input  wire logic [N_GRP*GRP_W-1:0]         pin_change_inputs,
  input  wire logic                           global_int_enable,
  input  wire logic                           sleep_active,
  input  wire logic [N_EXT-1:0]               ext_vector_ack,
  input  wire logic [N_GRP-1:0]               grp_vector_ack,
  output logic      [N_EXT-1:0]               ext_irq,
  output logic      [N_GRP-1:0]               pin_change_group_request,
  output logic                                wake_request
);

  localparam int N_PC = N_GRP * GRP_W;

  // Byte address of a register index
  function automatic logic hit(input logic [ext_irq_pkg::ADDR_W-1:0] addr,
                               input logic [7:0]                     idx);
    hit = (addr == {idx, ext_irq_pkg::BYTE_SHIFT});
  endfunction

  // Widen an 8-bit register to the bus word, upper bits zero
  function automatic logic [ext_irq_pkg::DATA_W-1:0] word(input logic [7:0] v);
    word = {{(ext_irq_pkg::DATA_W - ext_irq_pkg::REG_W){1'b0}}, v};
  endfunction

  // Register file
  logic [2*N_EXT-1:0] sense_control_reg;
  logic [N_EXT-1:0]   external_request_enable_reg;
  logic [N_EXT-1:0]   external_request_flags_reg;
  logic [N_EXT-1:0]   external_request_flags_next;
  logic [N_GRP-1:0]   pin_change_group_enable_reg;
  logic [N_GRP-1:0]   pin_change_group_flags_reg;
  logic [N_GRP-1:0]   pin_change_group_flags_next;
  logic [N_PC-1:0]    group_mask_reg;
  logic [ext_irq_pkg::DATA_W-1:0] prdata_reg;
  logic               pslverr_reg;

  // Bus decode
  logic setup_phase;
  logic wr_access;
  logic mapped;
  logic [7:0] wbyte;

  assign setup_phase = psel & ~penable;
  assign wr_access   = psel & penable & pwrite;
  assign wbyte       = pwdata[ext_irq_pkg::REG_W-1:0];

  always_comb begin
    mapped = hit(paddr, ext_irq_pkg::IDX_SENSE_CONTROL) |
             hit(paddr, ext_irq_pkg::IDX_EXT_ENABLE)    |
             hit(paddr, ext_irq_pkg::IDX_EXT_FLAGS)     |
             hit(paddr, ext_irq_pkg::IDX_GRP_ENABLE)    |
             hit(paddr, ext_irq_pkg::IDX_GRP_FLAGS)     |
             hit(paddr, ext_irq_pkg::IDX_MASK0)         |
             hit(paddr, ext_irq_pkg::IDX_MASK1)         |
             hit(paddr, ext_irq_pkg::IDX_MASK2)         |
             hit(paddr, ext_irq_pkg::IDX_MASK3);
  end

  // Input buffer of a disabled request pin is cut during sleep and reads low
  logic [N_EXT-1:0] ext_buffered;
  logic [N_EXT-1:0] buffer_cut;

  assign buffer_cut   = {N_EXT{sleep_active}} & ~external_request_enable_reg;
  assign ext_buffered = external_request_pins & ~buffer_cut;

  // Pins are sampled whatever their port direction, so a driven pin still fires
  logic [N_EXT-1:0] ext_sync;
  logic [N_PC-1:0]  pc_sync;

  pin_sync #(
    .W (N_EXT)
  ) u_ext_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (ext_buffered),
    .sync_out (ext_sync)
  );

  pin_sync #(
    .W (N_PC)
  ) u_pc_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pin_change_inputs),
    .sync_out (pc_sync)
  );

  // Previous synchronised values, for edge and change detection
  logic [N_EXT-1:0] ext_prev_reg;
  logic [N_PC-1:0]  pc_prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_reg <= '0;
      pc_prev_reg  <= '0;
    end else begin
      ext_prev_reg <= ext_sync;
      pc_prev_reg  <= pc_sync;
    end
  end

  // Sync and previous stages hold reset zeros for a few edges; a pin idling high
  // would look like an edge then, so detection waits until they are filled
  localparam int SETTLE_EDGES = 3;

  logic [SETTLE_EDGES-1:0] settle_reg;
  logic                    armed;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_reg <= '0;
    end else begin
      settle_reg <= {settle_reg[SETTLE_EDGES-2:0], 1'b1};
    end
  end

  assign armed = settle_reg[SETTLE_EDGES-1];

  // Sense decode of the external request pins
  logic [N_EXT-1:0] edge_fire;
  logic [N_EXT-1:0] level_mode;
  logic [N_EXT-1:0] level_low;

  sense_detect #(
    .N (N_EXT)
  ) u_sense_detect (
    .sense_select (sense_control_reg),
    .cur          (ext_sync),
    .prev         (ext_prev_reg),
    .edge_fire    (edge_fire),
    .level_mode   (level_mode),
    .level_low    (level_low)
  );

  // Masked changes per group
  logic [N_PC-1:0]  pc_change;
  logic [N_GRP-1:0] grp_change;

  assign pc_change = (pc_sync ^ pc_prev_reg) & group_mask_reg;

  always_comb begin
    for (int g = 0; g < N_GRP; g++) begin
      grp_change[g] = |pc_change[g*GRP_W +: GRP_W];
    end
  end

  // Write-one clear strobes
  logic [N_EXT-1:0] ext_w1c;
  logic [N_GRP-1:0] grp_w1c;

  assign ext_w1c = (wr_access && hit(paddr, ext_irq_pkg::IDX_EXT_FLAGS)) ?
                   wbyte[N_EXT-1:0] : '0;
  assign grp_w1c = (wr_access && hit(paddr, ext_irq_pkg::IDX_GRP_FLAGS)) ?
                   wbyte[N_GRP-1:0] : '0;

  // Vector entry and a write of one clear alike
  logic [N_EXT-1:0] ext_clear;
  logic [N_GRP-1:0] grp_clear;

  assign ext_clear = ext_w1c | ext_vector_ack;
  assign grp_clear = grp_w1c | grp_vector_ack;

  // Events are held off until the sampling stages carry real pin values
  logic [N_EXT-1:0] ext_event;
  logic [N_GRP-1:0] grp_event;

  assign ext_event = edge_fire & {N_EXT{armed}};
  assign grp_event = grp_change & {N_GRP{armed}};

  // A set in the same cycle as a clear wins, so no event is lost
  always_comb begin
    external_request_flags_next = (external_request_flags_reg & ~ext_clear) |
                                  ext_event;
    external_request_flags_next = external_request_flags_next & ~level_mode;
    pin_change_group_flags_next = (pin_change_group_flags_reg & ~grp_clear) |
                                  grp_event;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_request_flags_reg <= '0;
      pin_change_group_flags_reg <= '0;
    end else begin
      external_request_flags_reg <= external_request_flags_next;
      pin_change_group_flags_reg <= pin_change_group_flags_next;
    end
  end

  // Control registers, written at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_control_reg           <= ext_irq_pkg::RESET_VAL[2*N_EXT-1:0];
      external_request_enable_reg <= ext_irq_pkg::RESET_VAL[N_EXT-1:0];
      pin_change_group_enable_reg <= ext_irq_pkg::RESET_VAL[N_GRP-1:0];
    end else if (wr_access) begin
      if (hit(paddr, ext_irq_pkg::IDX_SENSE_CONTROL)) begin
        sense_control_reg <= wbyte[2*N_EXT-1:0];
      end
      if (hit(paddr, ext_irq_pkg::IDX_EXT_ENABLE)) begin
        external_request_enable_reg <= wbyte[N_EXT-1:0];
      end
      if (hit(paddr, ext_irq_pkg::IDX_GRP_ENABLE)) begin
        pin_change_group_enable_reg <= wbyte[N_GRP-1:0];
      end
    end
  end

  // Mask registers, one byte per group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_mask_reg <= '0;
    end else if (wr_access) begin
      if (hit(paddr, ext_irq_pkg::IDX_MASK0)) begin
        group_mask_reg[0*GRP_W +: GRP_W] <= wbyte;
      end
      if (hit(paddr, ext_irq_pkg::IDX_MASK1)) begin
        group_mask_reg[1*GRP_W +: GRP_W] <= wbyte;
      end
      if (hit(paddr, ext_irq_pkg::IDX_MASK2)) begin
        group_mask_reg[2*GRP_W +: GRP_W] <= wbyte;
      end
      if (hit(paddr, ext_irq_pkg::IDX_MASK3)) begin
        group_mask_reg[3*GRP_W +: GRP_W] <= wbyte;
      end
    end
  end

  // Read data is captured in the setup cycle so pready can stay high
  logic [7:0] read_byte;

  always_comb begin
    read_byte = '0;
    if (hit(paddr, ext_irq_pkg::IDX_SENSE_CONTROL)) begin
      read_byte[2*N_EXT-1:0] = sense_control_reg;
    end else if (hit(paddr, ext_irq_pkg::IDX_EXT_ENABLE)) begin
      read_byte[N_EXT-1:0] = external_request_enable_reg;
    end else if (hit(paddr, ext_irq_pkg::IDX_EXT_FLAGS)) begin
      read_byte[N_EXT-1:0] = external_request_flags_reg;
    end else if (hit(paddr, ext_irq_pkg::IDX_GRP_ENABLE)) begin
      read_byte[N_GRP-1:0] = pin_change_group_enable_reg;
    end else if (hit(paddr, ext_irq_pkg::IDX_GRP_FLAGS)) begin
      read_byte[N_GRP-1:0] = pin_change_group_flags_reg;
    end else if (hit(paddr, ext_irq_pkg::IDX_MASK0)) begin
      read_byte = group_mask_reg[0*GRP_W +: GRP_W];
    end else if (hit(paddr, ext_irq_pkg::IDX_MASK1)) begin
      read_byte = group_mask_reg[1*GRP_W +: GRP_W];
    end else if (hit(paddr, ext_irq_pkg::IDX_MASK2)) begin
      read_byte = group_mask_reg[2*GRP_W +: GRP_W];
    end else if (hit(paddr, ext_irq_pkg::IDX_MASK3)) begin
      read_byte = group_mask_reg[3*GRP_W +: GRP_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg  <= pwrite ? '0 : word(read_byte);
      pslverr_reg <= ~mapped;
    end
  end

  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg & psel & penable;
  assign pready  = 1'b1;

  // Level mode requests straight from the pin: a level that has gone wakes only
  logic [N_EXT-1:0] level_req;
  logic [N_EXT-1:0] edge_req;

  assign level_req = level_mode & level_low;
  assign edge_req  = ~level_mode & external_request_flags_reg;

  // Interrupt requests toward the vector logic
  always_comb begin
    ext_irq = {N_EXT{global_int_enable}} & external_request_enable_reg &
              (level_req | edge_req);
    pin_change_group_request = pin_change_group_flags_reg &
                               pin_change_group_enable_reg &
                               {N_GRP{global_int_enable}};
  end

  // Wake path uses the raw pins so it works while the clock is stopped
  logic [N_EXT-1:0] wake_ext;
  logic [N_PC-1:0]  grp_en_wide;
  logic [N_PC-1:0]  wake_pc;
  logic [N_GRP-1:0] wake_grp;

  always_comb begin
    for (int g = 0; g < N_GRP; g++) begin
      grp_en_wide[g*GRP_W +: GRP_W] = {GRP_W{pin_change_group_enable_reg[g]}};
    end
    for (int i = 0; i < N_EXT; i++) begin
      wake_ext[i] = external_request_enable_reg[i] &
                    (level_mode[i] ? ~ext_buffered[i]
                                   : (ext_buffered[i] ^ ext_sync[i]));
    end
    wake_pc = (pin_change_inputs ^ pc_sync) & group_mask_reg & grp_en_wide;
    for (int g = 0; g < N_GRP; g++) begin
      wake_grp[g] = |wake_pc[g*GRP_W +: GRP_W];
    end
  end

  assign wake_request = |wake_ext | |wake_grp;

endmodule

// ### test/ext_irq_partner.sv
// Model of the CPU vector logic that answers pending interrupt requests
`timescale 1ns/1ps
module ext_irq_partner (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       enable,
  input  wire logic [3:0] delay,
  input  wire logic [6:0] req,
  output logic      [6:0] ack
);
  logic [3:0] wait_cnt;

  // Vector entry pulses one cycle for the lowest pending request; a gap follows each pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack      <= 7'h00;
      wait_cnt <= 4'h0;
    end else if (ack != 7'h00) begin
      ack <= 7'h00;
    end else if (enable && req != 7'h00) begin
      if (wait_cnt == delay) begin
        ack      <= req & (~req + 7'h01);
        wait_cnt <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule

// ### test/ext_irq_chk.sv
// Checker of request gating, flag timing and bus answers of the interrupt unit
`timescale 1ns/1ps
module ext_irq_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  external_request_pins,
  input wire logic [31:0] pin_change_inputs,
  input wire logic        global_int_enable,
  input wire logic        sleep_active,
  input wire logic [2:0]  ext_vector_ack,
  input wire logic [3:0]  grp_vector_ack,
  input wire logic [2:0]  ext_irq,
  input wire logic [3:0]  pin_change_group_request
);
  logic [2:0]  quiet;
  logic [35:0] pins_d;
  wire  [35:0] pins = {sleep_active, external_request_pins, pin_change_inputs};
  wire  [6:0]  req  = {pin_change_group_request, ext_irq};
  wire  [6:0]  ack  = {grp_vector_ack, ext_vector_ack};
  wire         wr   = psel && penable && pwrite;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Edges since the pins last moved; requests may only move within three edges after a change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet  <= 3'h0;
      pins_d <= 36'h0;
    end else begin
      pins_d <= pins;
      quiet  <= (pins != pins_d) ? 3'h0 : ((quiet == 3'h7) ? quiet : quiet + 3'h1);
    end
  end

  req_rise_a: assert property (
    (req & ~$past(req)) != 7'h00 |-> quiet < 3'h4 || $past(wr) || $rose(global_int_enable))
    else $error("Request rose without a pin change, write or global enable");
  req_fall_a: assert property (
    ($past(req) & ~req & ~$past(ack)) != 7'h00
      |-> quiet < 3'h4 || $past(wr) || $fell(global_int_enable))
    else $error("Request dropped without a cause");
  ack_clear_a: assert property (
    quiet >= 3'h4 && grp_vector_ack != 4'h0
      |=> (pin_change_group_request & $past(grp_vector_ack)) == 4'h0)
    else $error("Group request survived its vector entry");
  ext_gate_a: assert property (ext_irq != 3'h0 |-> global_int_enable)
    else $error("Pin request without global enable");
  grp_gate_a: assert property (pin_change_group_request != 4'h0 |-> global_int_enable)
    else $error("Group request without global enable");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("Bus error outside an access phase");
  err_zero_a: assert property (pslverr |-> prdata == 32'h0)
    else $error("Bus error with nonzero read data");
  ready_now_a: assert property (psel && penable |-> pready)
    else $error("Access phase not answered at once");

  cover property ($rose(ext_irq[0]));
  cover property (grp_vector_ack != 4'h0);
  cover property (pslverr);
endmodule

bind external_pin_interrupt_unit ext_irq_chk chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .external_request_pins(external_request_pins), .pin_change_inputs(pin_change_inputs),
  .global_int_enable(global_int_enable), .sleep_active(sleep_active),
  .ext_vector_ack(ext_vector_ack), .grp_vector_ack(grp_vector_ack), .ext_irq(ext_irq),
  .pin_change_group_request(pin_change_group_request));

// ### test/external_pin_interrupt_unit_bench.sv
// Self-checking bench of the external pin and pin-change interrupt unit
`timescale 1ns/1ps
module external_pin_interrupt_unit_bench;
  localparam logic [7:0] REGS [9] = '{ext_irq_pkg::IDX_MASK0, ext_irq_pkg::IDX_MASK1,
    ext_irq_pkg::IDX_MASK2, ext_irq_pkg::IDX_MASK3, ext_irq_pkg::IDX_SENSE_CONTROL,
    ext_irq_pkg::IDX_EXT_ENABLE, ext_irq_pkg::IDX_EXT_FLAGS, ext_irq_pkg::IDX_GRP_ENABLE,
    ext_irq_pkg::IDX_GRP_FLAGS};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  ext_pins = 3'h7;
  logic [31:0] pc_in = 32'h0;
  logic        gie = 1'b0;
  logic        sleep = 1'b0;
  logic        auto_ack = 1'b0;
  logic [3:0]  ack_delay = 4'h0;
  logic [6:0]  acks;
  logic [2:0]  ext_irq;
  logic [3:0]  grp_req;
  logic        wake;
  int          fails = 0;
  int          comparisons = 0;

  always #12.5 pclk = ~pclk;

  external_pin_interrupt_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_request_pins(ext_pins),
    .pin_change_inputs(pc_in), .global_int_enable(gie), .sleep_active(sleep),
    .ext_vector_ack(acks[2:0]), .grp_vector_ack(acks[6:3]), .ext_irq(ext_irq),
    .pin_change_group_request(grp_req), .wake_request(wake));
  ext_irq_partner cpu (.pclk(pclk), .presetn(presetn), .enable(auto_ack), .delay(ack_delay),
    .req({grp_req, ext_irq}), .ack(acks));

  function automatic logic edge_hit(input logic [1:0] s, input logic rising);
    return s == ext_irq_pkg::SENSE_ANY ||
           s == (rising ? ext_irq_pkg::SENSE_RISE : ext_irq_pkg::SENSE_FALL);
  endfunction

  task automatic conclude();
    if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Ends one edge after release so the next call never drives psel twice in a step
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     output logic [7:0] rd, output logic err);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    conclude();
  end

  initial begin
    logic [7:0] rd;
    logic [7:0] m;
    logic [1:0] s;
    logic       err;
    int         g;
    int         b;
    g = $urandom(74);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, REGS[i], 8'h00, rd, err);
      check("reset value", 8'h00, rd);
    end
    apb(1'b1, 8'h00, 8'hff, rd, err);
    check("unmapped error", 8'h01, {7'h0, err});
    apb(1'b1, REGS[4], 8'hff, rd, err);
    apb(1'b0, REGS[4], 8'h00, rd, err);
    check("sense control", 8'h3f, rd);
    gie <= 1'b1;
    for (int mode = 1; mode < 4; mode++) begin
      s = mode[1:0];
      apb(1'b1, REGS[5], 8'h00, rd, err);
      apb(1'b1, REGS[4], {2'b00, s, s, s}, rd, err);
      apb(1'b1, REGS[6], 8'h07, rd, err);
      apb(1'b1, REGS[5], 8'h07, rd, err);
      for (int up = 0; up < 2; up++) begin
        ext_pins <= {3{up[0]}};
        repeat (4) @(posedge pclk);
        apb(1'b0, REGS[6], 8'h00, rd, err);
        check("edge flags", edge_hit(s, up[0]) ? 8'h07 : 8'h00, rd);
        check("edge request", edge_hit(s, up[0]) ? 8'h07 : 8'h00, {5'h0, ext_irq});
        apb(1'b1, REGS[6], 8'h07, rd, err);
      end
    end
    apb(1'b1, REGS[5], 8'h00, rd, err);
    apb(1'b1, REGS[4], 8'h00, rd, err);
    apb(1'b1, REGS[5], 8'h07, rd, err);
    // Low level held for many cycles, well past one instruction
    ext_pins <= 3'h5;
    repeat (12) @(posedge pclk);
    check("level request", 8'h02, {5'h0, ext_irq});
    check("level wake", 8'h01, {7'h0, wake});
    apb(1'b0, REGS[6], 8'h00, rd, err);
    check("level flags", 8'h00, rd);
    gie <= 1'b0;
    @(posedge pclk);
    check("level masked", 8'h00, {5'h0, ext_irq});
    gie      <= 1'b1;
    ext_pins <= 3'h7;
    apb(1'b1, REGS[5], 8'h00, rd, err);
    apb(1'b1, REGS[4], 8'h02, rd, err);
    apb(1'b1, REGS[6], 8'h07, rd, err);
    sleep <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, REGS[6], 8'h00, rd, err);
    check("sleep cut flag", 8'h01, rd);
    sleep <= 1'b0;
    apb(1'b1, REGS[7], 8'h0f, rd, err);
    for (int r = 0; r < 12; r++) begin
      g = $urandom % 4;
      b = $urandom % 8;
      m = (r == 0) ? 8'h00 : ((r == 1) ? 8'hff : 8'($urandom));
      apb(1'b1, REGS[g], m, rd, err);
      apb(1'b0, REGS[g], 8'h00, rd, err);
      check("mask", m, rd);
      pc_in <= pc_in ^ (32'h1 << (8 * g + b));
      @(posedge pclk);
      check("change wake", {7'h0, m[b]}, {7'h0, wake});
      repeat (3) @(posedge pclk);
      apb(1'b0, REGS[8], 8'h00, rd, err);
      check("group flags", m[b] ? (8'h01 << g) : 8'h00, rd);
      check("group request", m[b] ? (8'h01 << g) : 8'h00, {4'h0, grp_req});
      apb(1'b1, REGS[8], 8'h0f, rd, err);
      apb(1'b0, REGS[8], 8'h00, rd, err);
      check("group flags cleared", 8'h00, rd);
    end
    apb(1'b1, REGS[0], 8'hff, rd, err);
    gie   <= 1'b0;
    pc_in <= pc_in ^ 32'h1;
    repeat (4) @(posedge pclk);
    check("group request masked", 8'h00, {4'h0, grp_req});
    apb(1'b0, REGS[8], 8'h00, rd, err);
    check("group flag pending", 8'h01, rd);
    ack_delay <= 4'($urandom % 8);
    auto_ack  <= 1'b1;
    gie       <= 1'b1;
    repeat (14) @(posedge pclk);
    apb(1'b0, REGS[8], 8'h00, rd, err);
    check("flag cleared on entry", 8'h00, rd);
    conclude();
  end
endmodule
